// >>> logic/sss_regs.vh
// Purpose: Register map, field positions, defaults and timing for the
//          sweep source sequencer.
// Assumes: Voltages are signed counts of 10 mV; times are counts of 10 ms.
// Notes:   Definitions only.
`ifndef SSS_REGS_VH
`define SSS_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SSS_OFF_CTRL    8'h00
`define SSS_OFF_HIGH    8'h04
`define SSS_OFF_LOW     8'h08
`define SSS_OFF_BASE    8'h0c
`define SSS_OFF_STEP    8'h10
`define SSS_OFF_DELAY   8'h14
`define SSS_OFF_STATUS  8'h18
`define SSS_OFF_COUNT   8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSS_CTRL_WAVE_LSB  0
`define SSS_CTRL_CAP_BIT   2
`define SSS_CTRL_CLR_BIT   3
`define SSS_STAT_HALT_BIT  12
`define SSS_STAT_WAVE_LSB  13
`define SSS_STAT_PAR_BIT   15

// ----------------------------------------------------------------------
// Waveform codes
// ----------------------------------------------------------------------
`define SSS_WAVE_OFF    2'h0
`define SSS_WAVE_DC     2'h1
`define SSS_WAVE_SQUARE 2'h2
`define SSS_WAVE_STAIR  2'h3

// ----------------------------------------------------------------------
// Limits and defaults (10 mV units, delay in 10 ms units)
// ----------------------------------------------------------------------
`define SSS_VOLT_MAX    12'sd2000
`define SSS_VOLT_MIN    -12'sd2000
`define SSS_DEF_HIGH    12'sd2000
`define SSS_DEF_LOW     -12'sd2000
`define SSS_DEF_BASE    12'sd0
`define SSS_DEF_STEP    3'h2
`define SSS_DEF_WAVE    2'h2
`define SSS_DELAY_MIN   15'd7
`define SSS_DELAY_MAX   15'd19999
`define SSS_DEF_DELAY   15'd7
`define SSS_OVERHEAD    15'd4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSS_CLK_HZ      200000000
`define SSS_TICK_MS     10
`define SSS_TICK_CYCLES (`SSS_CLK_HZ / 1000 * `SSS_TICK_MS)

`endif

// >>> logic/sss_sequencer.v
// Purpose: Sweep source sequencer: limits, base level, step code, delay
//          timer and waveform sequencing, reached over APB.
// Assumes: One clock, clk at 200 MHz; host writes binary settings.
// Notes:   srcLevel is signed, in 10 mV units.
`default_nettype none
`include "sss_regs.vh"

module sss_sequencer #(
  parameter TICK_CYCLES = `SSS_TICK_CYCLES
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [11:0] srcLevel,
  output wire        measTrig,
  output wire        readingValid,
  output wire        stepStart
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function signed [11:0] stepValue;
    input [2:0] code;
    reg   signed [11:0] mag;
    begin
      case (code[1:0])
        2'h0:    mag = 12'sd1;
        2'h1:    mag = 12'sd2;
        2'h2:    mag = 12'sd5;
        default: mag = 12'sd10;
      endcase
      stepValue = code[2] ? -mag : mag;
    end
  endfunction

  function signed [11:0] clampLevel;
    input signed [12:0] v;
    input signed [11:0] lo;
    input signed [11:0] hi;
    begin
      // Signed compares: a bare concatenation would compare unsigned.
      if (v > $signed({hi[11], hi})) begin
        clampLevel = hi;
      end else if (v < $signed({lo[11], lo})) begin
        clampLevel = lo;
      end else begin
        clampLevel = v[11:0];
      end
    end
  endfunction

  function inRange;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      inRange = (v >= lo) && (v <= hi);
    end
  endfunction

  function [31:0] signExt;
    input [11:0] v;
    begin
      signExt = {{20{v[11]}}, v};
    end
  endfunction

  // --------------------------------------------------------------------
  // Settings
  // --------------------------------------------------------------------
  reg signed [11:0] highLimit_reg;
  reg signed [11:0] lowLimit_reg;
  reg signed [11:0] baseLevel_reg;
  reg        [2:0]  stepCode_reg;
  reg        [14:0] delayTicks_reg;
  reg        [1:0]  wave_reg;
  reg               capMode_reg;
  reg               holdDc_reg;
  reg               halted_reg;
  reg signed [11:0] stairLevel_reg;
  reg               squareHigh_reg;
  reg               parity_reg;
  reg        [31:0] tickDiv_reg;
  reg        [14:0] stepTicks_reg;
  reg               measDone_reg;
  reg        [15:0] readCount_reg;
  reg signed [11:0] level_reg;
  reg               measPulse_reg;
  reg               readPulse_reg;
  reg               stepPulse_reg;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire access = psel & penable;
  wire wrEn   = access & pwrite;
  wire signed [31:0] wdS = $signed(pwdata);

  wire hitCtrl  = (paddr == `SSS_OFF_CTRL);
  wire hitHigh  = (paddr == `SSS_OFF_HIGH);
  wire hitLow   = (paddr == `SSS_OFF_LOW);
  wire hitBase  = (paddr == `SSS_OFF_BASE);
  wire hitStep  = (paddr == `SSS_OFF_STEP);
  wire hitDelay = (paddr == `SSS_OFF_DELAY);
  wire hitStat  = (paddr == `SSS_OFF_STATUS);
  wire hitCount = (paddr == `SSS_OFF_COUNT);
  wire mapped   = hitCtrl | hitHigh | hitLow | hitBase | hitStep |
                  hitDelay | hitStat | hitCount;

  // Values are taken as whole numbers, so no digit padding is required
  // from the host.
  wire okHigh  = inRange(wdS, `SSS_VOLT_MIN, `SSS_VOLT_MAX) &&
                 (wdS >= $signed(signExt(baseLevel_reg)));
  wire okLow   = inRange(wdS, `SSS_VOLT_MIN, `SSS_VOLT_MAX) &&
                 (wdS <= $signed(signExt(baseLevel_reg)));
  wire okBase  = (wdS >= $signed(signExt(lowLimit_reg))) &&
                 (wdS <= $signed(signExt(highLimit_reg)));
  wire okDelay = (pwdata <= {17'h0, `SSS_DELAY_MAX}) &&
                 (pwdata >= {17'h0, `SSS_DELAY_MIN});
  wire okStep  = (pwdata[31:3] == 29'h0);
  wire okCtrl  = (pwdata[31:4] == 28'h0);

  // Out-of-range settings are refused and the old value kept, so a
  // mistyped command cannot move the source past a limit.
  wire badWr = wrEn & ((hitHigh & ~okHigh) | (hitLow & ~okLow) |
               (hitBase & ~okBase) | (hitDelay & ~okDelay) |
               (hitStep & ~okStep) | (hitCtrl & ~okCtrl) |
               hitStat | hitCount);

  assign pready  = access;
  assign pslverr = access & (~mapped | badWr);

  wire wrCtrl  = wrEn & hitCtrl & okCtrl;
  wire devClr  = wrCtrl & pwdata[`SSS_CTRL_CLR_BIT];
  wire wrWave  = wrCtrl & ~devClr;
  wire [1:0] newWave = pwdata[`SSS_CTRL_WAVE_LSB +: 2];

  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0;
    if (hitCtrl) begin
      rdMux = {28'h0, 1'b0, capMode_reg, wave_reg};
    end else if (hitHigh) begin
      rdMux = signExt(highLimit_reg);
    end else if (hitLow) begin
      rdMux = signExt(lowLimit_reg);
    end else if (hitBase) begin
      rdMux = signExt(baseLevel_reg);
    end else if (hitStep) begin
      rdMux = {29'h0, stepCode_reg};
    end else if (hitDelay) begin
      rdMux = {17'h0, delayTicks_reg};
    end else if (hitStat) begin
      rdMux = {16'h0, parity_reg, wave_reg, halted_reg, level_reg};
    end else if (hitCount) begin
      rdMux = {16'h0, readCount_reg};
    end
  end
  assign prdata = (access & ~pwrite) ? rdMux : 32'h0;

  // --------------------------------------------------------------------
  // Step timing
  // --------------------------------------------------------------------
  // One tick is 10 ms of clocks; steps and delays count in ticks.
  wire tick     = (tickDiv_reg == TICK_CYCLES - 1);
  wire delayHit = tick & ~measDone_reg &
                  (stepTicks_reg + 15'd1 == delayTicks_reg);
  wire stepEnd  = tick &
                  (stepTicks_reg + 15'd1 == delayTicks_reg + `SSS_OVERHEAD);
  // A waveform change restarts the step so a partial step never
  // produces a measurement with a short settling time.
  // A new delay restarts it too: a delay cut below the ticks already
  // counted would otherwise miss the end compare until the counter wraps.
  wire wrDelay  = wrEn & hitDelay & okDelay;
  wire restart  = wrWave | devClr | wrDelay;

  wire signed [11:0] stepV    = stepValue(stepCode_reg);
  wire signed [12:0] stairSum = {stairLevel_reg[11], stairLevel_reg} +
                                {stepV[11], stepV};
  wire signed [11:0] stairNext = clampLevel(stairSum, lowLimit_reg,
                                            highLimit_reg);
  wire hitBound = stepV[11] ? (stairNext == lowLimit_reg)
                            : (stairNext == highLimit_reg);
  wire signed [12:0] sqSum = {baseLevel_reg[11], baseLevel_reg} +
                             {stepV[11], stepV};

  // --------------------------------------------------------------------
  // Output level
  // --------------------------------------------------------------------
  // A bound moved inside the staircase level takes hold at once.
  wire signed [11:0] stairClamp =
    clampLevel({stairLevel_reg[11], stairLevel_reg}, lowLimit_reg,
               highLimit_reg);

  // Level is registered so the source never sees decode glitches.
  reg signed [11:0] level_next;
  always @* begin
    case (wave_reg)
      `SSS_WAVE_OFF: begin
        level_next = 12'sd0;
      end
      `SSS_WAVE_DC: begin
        level_next = holdDc_reg ? stairClamp : baseLevel_reg;
      end
      `SSS_WAVE_SQUARE: begin
        level_next = squareHigh_reg ?
          clampLevel(sqSum, lowLimit_reg, highLimit_reg) :
          baseLevel_reg;
      end
      `SSS_WAVE_STAIR: begin
        level_next = stairClamp;
      end
      default: begin
        level_next = 12'sd0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      highLimit_reg  <= `SSS_DEF_HIGH;
      lowLimit_reg   <= `SSS_DEF_LOW;
      baseLevel_reg  <= `SSS_DEF_BASE;
      stepCode_reg   <= `SSS_DEF_STEP;
      delayTicks_reg <= `SSS_DEF_DELAY;
      wave_reg       <= `SSS_DEF_WAVE;
      capMode_reg    <= 1'b0;
      holdDc_reg     <= 1'b0;
      halted_reg     <= 1'b0;
      stairLevel_reg <= `SSS_DEF_BASE;
      squareHigh_reg <= 1'b0;
      parity_reg     <= 1'b0;
      tickDiv_reg    <= 32'h0;
      stepTicks_reg  <= 15'h0;
      measDone_reg   <= 1'b0;
      readCount_reg  <= 16'h0;
      level_reg      <= 12'sd0;
      measPulse_reg  <= 1'b0;
      readPulse_reg  <= 1'b0;
      stepPulse_reg  <= 1'b0;
    end else begin
      // Pulses fall back each clock so they stand one cycle only.
      measPulse_reg <= 1'b0;
      readPulse_reg <= 1'b0;
      stepPulse_reg <= 1'b0;
      level_reg     <= level_next;

      if (devClr) begin
        highLimit_reg  <= `SSS_DEF_HIGH;
        lowLimit_reg   <= `SSS_DEF_LOW;
        baseLevel_reg  <= `SSS_DEF_BASE;
        stepCode_reg   <= `SSS_DEF_STEP;
        delayTicks_reg <= `SSS_DEF_DELAY;
        wave_reg       <= `SSS_DEF_WAVE;
        capMode_reg    <= 1'b0;
        holdDc_reg     <= 1'b0;
        halted_reg     <= 1'b0;
        stairLevel_reg <= `SSS_DEF_BASE;
        squareHigh_reg <= 1'b0;
        parity_reg     <= 1'b0;
      end else begin
        if (wrEn & hitHigh & okHigh) begin
          highLimit_reg <= pwdata[11:0];
        end
        if (wrEn & hitLow & okLow) begin
          lowLimit_reg <= pwdata[11:0];
        end
        // Storing the base feeds straight into the square and host-selected DC output levels; the halt-hold DC keeps the stair level.
        if (wrEn & hitBase & okBase) begin
          baseLevel_reg <= pwdata[11:0];
        end
        if (wrEn & hitStep & okStep) begin
          stepCode_reg <= pwdata[2:0];
        end
        if (wrEn & hitDelay & okDelay) begin
          delayTicks_reg <= pwdata[14:0];
        end
        if (wrWave) begin
          wave_reg    <= newWave;
          capMode_reg <= pwdata[`SSS_CTRL_CAP_BIT];
          holdDc_reg  <= 1'b0;
          halted_reg  <= 1'b0;
          parity_reg  <= 1'b0;
          squareHigh_reg <= 1'b0;
          // Reselecting the staircase from a host-selected DC resumes from the last
          // stair level; from the halt hold or any other waveform it starts over at base.
          if (newWave == `SSS_WAVE_STAIR &&
              !(wave_reg == `SSS_WAVE_DC && holdDc_reg == 1'b0 &&
                halted_reg == 1'b0 && wave_reg != newWave &&
                stairLevel_reg != baseLevel_reg)) begin
            stairLevel_reg <= baseLevel_reg;
          end
        end else if (stepEnd) begin
          stepPulse_reg <= 1'b1;
          squareHigh_reg <= ~squareHigh_reg;
          if (wave_reg == `SSS_WAVE_STAIR) begin
            stairLevel_reg <= stairNext;
            if (hitBound) begin
              wave_reg   <= `SSS_WAVE_DC;
              holdDc_reg <= 1'b1;
              halted_reg <= 1'b1;
            end
          end
        end
        if (delayHit & ~restart) begin
          measPulse_reg <= 1'b1;
          parity_reg    <= ~parity_reg;
          // Capacitance needs both edges of a step pair.
          if (!capMode_reg || parity_reg) begin
            readPulse_reg <= 1'b1;
            readCount_reg <= readCount_reg + 16'h1;
          end
        end
      end

      if (restart) begin
        tickDiv_reg   <= 32'h0;
        stepTicks_reg <= 15'h0;
        measDone_reg  <= 1'b0;
      end else begin
        tickDiv_reg <= tick ? 32'h0 : tickDiv_reg + 32'h1;
        if (stepEnd) begin
          stepTicks_reg <= 15'h0;
          measDone_reg  <= 1'b0;
        end else if (tick) begin
          stepTicks_reg <= stepTicks_reg + 15'h1;
          if (delayHit) begin
            measDone_reg <= 1'b1;
          end
        end
      end
    end
  end

  assign srcLevel     = level_reg;
  assign measTrig     = measPulse_reg;
  assign readingValid = readPulse_reg;
  assign stepStart    = stepPulse_reg;

endmodule // sss_sequencer
`default_nettype wire

// >>> dv/sss_host_model.sv
// Purpose: APB host that writes and reads the sequencer settings.
// Assumes: One transfer at a time; waits for pready however late.
// Notes:   Released address and data are inverted, never left stale.
`default_nettype none
module sss_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Settings stay in span and base between bounds, unless refusal is meant
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // sss_host_model
`default_nettype wire

// >>> dv/sss_sequencer_asserts.sv
// Purpose: Port-level checks of the sweep source sequencer.
// Assumes: One clock domain; readingValid coincides with measTrig.
// Notes:   Bound to every sequencer instance.
`default_nettype none
`include "sss_regs.vh"
module sss_sequencer_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] srcLevel,
  input wire logic        measTrig,
  input wire logic        readingValid,
  input wire logic        stepStart
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [15:0] sinceTrig_reg;
  // A write may retime the step, so the span count is cleared until the next trigger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sinceTrig_reg <= 16'h0000;
    end else if (measTrig) begin
      sinceTrig_reg <= 16'h0001;
    end else if (psel && penable && pwrite) begin
      sinceTrig_reg <= 16'h0000;
    end else if (sinceTrig_reg != 16'h0000 && sinceTrig_reg != 16'hffff) begin
      sinceTrig_reg <= sinceTrig_reg + 16'h0001;
    end
  end
  sequence s_write(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  property p_highSpan;
    s_write(`SSS_OFF_HIGH) ##0 ($signed(pwdata) > 2000) |-> pslverr;
  endproperty
  a_highSpan: assert property (p_highSpan)
    else $error("high accepted");
  property p_lowSpan;
    s_write(`SSS_OFF_LOW) ##0 ($signed(pwdata) < -2000) |-> pslverr;
  endproperty
  a_lowSpan: assert property (p_lowSpan) else $error("low accepted");
  property p_delaySpan;
    s_write(`SSS_OFF_DELAY) ##0 (pwdata < 32'd7 || pwdata > 32'd19999)
      |-> pslverr;
  endproperty
  a_delaySpan: assert property (p_delaySpan) else $error("delay ok");
  property p_stepCode;
    s_write(`SSS_OFF_STEP) ##0 (pwdata[31:3] != 29'h0) |-> pslverr;
  endproperty
  a_stepCode: assert property (p_stepCode) else $error("step ok");
  property p_levelSpan;
    $signed(srcLevel) <= 2000 && $signed(srcLevel) >= -2000;
  endproperty
  a_levelSpan: assert property (p_levelSpan) else $error("level");
  property p_resetLevel;
    $rose(rst_b) |-> srcLevel == 12'h000;
  endproperty
  a_resetLevel: assert property (p_resetLevel) else $error("rst");
  property p_trigSpace;
    measTrig |=> (!measTrig) [*8];
  endproperty
  a_trigSpace: assert property (p_trigSpace) else $error("trig");
  property p_stepAfterTrig;
    stepStart && sinceTrig_reg != 16'h0000
      |-> sinceTrig_reg == 16'(4 * TICK_CYCLES);
  endproperty
  a_stepAfterTrig: assert property (p_stepAfterTrig)
    else $error("span");
  property p_stepAlone;
    stepStart |-> !measTrig ##1 !stepStart;
  endproperty
  a_stepAlone: assert property (p_stepAlone) else $error("step");
  property p_readingOnTrig;
    readingValid |-> measTrig;
  endproperty
  a_readingOnTrig: assert property (p_readingOnTrig)
    else $error("rdg");
endmodule // sss_sequencer_asserts
bind sss_sequencer sss_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES))
  sss_sequencer_asserts_i (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .srcLevel(srcLevel), .measTrig(measTrig), .readingValid(readingValid),
  .stepStart(stepStart));
`default_nettype wire

// >>> dv/sss_sequencer_tb.sv
// Purpose: Self-checking bench for the sweep source sequencer.
// Assumes: TICK_CYCLES cut to 4 so a 0.07 s delay is 28 clocks.
// Notes:   Pulses are sampled on the falling edge, where they settle.
`default_nettype none
`include "sss_regs.vh"
module sss_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 4;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] srcLevel;
  logic        measTrig, readingValid, stepStart;
  int          error_cnt = 0;
  int          n_compared = 0;
  sss_sequencer #(.TICK_CYCLES(TICK)) sss_sequencer_i (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcLevel(srcLevel), .measTrig(measTrig),
    .readingValid(readingValid), .stepStart(stepStart));
  sss_host_model sss_host_model_i (.clk(clk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] rd;
    logic        err;
    sss_host_model_i.xfer(1'b1, a, d, rd, err);
    chk({31'h0, err}, {31'h0, e});
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] mask = 32'hffffffff);
    logic [31:0] rd;
    logic        err;
    sss_host_model_i.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd & mask, exp);
  endtask
  // Falling edges until the pulse: sel 0 trigger, 1 step end
  task automatic waitSig(input int sel, output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (((sel == 0) ? measTrig : stepStart) !== 1'b1 && cyc < 4000);
    // A pulse that never comes is a failure, not a silent return
    if (((sel == 0) ? measTrig : stepStart) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
  endtask
  function automatic logic [31:0] lvl();
    return {{20{srcLevel[11]}}, srcLevel};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    rdChk(`SSS_OFF_HIGH, 32'd2000);
    rdChk(`SSS_OFF_LOW, 32'hfffff830);
    rdChk(`SSS_OFF_BASE, 32'h0);
    rdChk(`SSS_OFF_STEP, 32'h2);
    rdChk(`SSS_OFF_DELAY, 32'd7);
    rdChk(`SSS_OFF_CTRL, 32'h2);
  endtask
  task automatic t_refuse();
    wr(`SSS_OFF_HIGH, 32'd2001, 1'b1);
    wr(`SSS_OFF_LOW, 32'hfffff82f, 1'b1);
    wr(`SSS_OFF_HIGH, 32'd100, 1'b0);
    wr(`SSS_OFF_BASE, 32'd101, 1'b1);
    wr(`SSS_OFF_HIGH, 32'hffffffff, 1'b1);
    rdChk(`SSS_OFF_HIGH, 32'd100);
    wr(`SSS_OFF_DELAY, 32'd6, 1'b1);
    wr(`SSS_OFF_DELAY, 32'd20000, 1'b1);
    wr(`SSS_OFF_DELAY, 32'd19999, 1'b0);
    rdChk(`SSS_OFF_DELAY, 32'd19999);
    wr(`SSS_OFF_STEP, 32'h8, 1'b1);
    wr(`SSS_OFF_STATUS, 32'h0, 1'b1);
    rdChk(8'h20, 32'h0);
  endtask
  task automatic t_timing();
    int c;
    wr(`SSS_OFF_DELAY, 32'd10, 1'b0);
    wr(`SSS_OFF_CTRL, 32'h0, 1'b0);
    wr(`SSS_OFF_BASE, 32'd50, 1'b0);
    repeat (3) @(negedge clk);
    chk(lvl(), 32'h0);
    wr(`SSS_OFF_CTRL, 32'h1, 1'b0);
    waitSig(1, c);
    chk(lvl(), 32'd50);
    waitSig(0, c);
    chk(c, 32'd40);
    waitSig(1, c);
    chk(c, 32'd16);
  endtask
  task automatic t_stair();
    int c;
    wr(`SSS_OFF_DELAY, 32'd7, 1'b0);
    wr(`SSS_OFF_BASE, 32'd0, 1'b0);
    wr(`SSS_OFF_HIGH, 32'd30, 1'b0);
    wr(`SSS_OFF_STEP, 32'h3, 1'b0);
    wr(`SSS_OFF_CTRL, 32'h3, 1'b0);
    repeat (6) waitSig(1, c);
    chk(lvl(), 32'd30);
    rdChk(`SSS_OFF_STATUS, 32'h301e, 32'h7fff);
    wr(`SSS_OFF_LOW, 32'hffffffec, 1'b0);
    wr(`SSS_OFF_STEP, 32'h6, 1'b0);
    wr(`SSS_OFF_CTRL, 32'h3, 1'b0);
    repeat (6) waitSig(1, c);
    chk(lvl(), 32'hffffffec);
    rdChk(`SSS_OFF_STATUS, 32'h3fec, 32'h7fff);
  endtask
  task automatic t_codes();
    int c;
    logic [31:0] stepv [8] = '{1, 2, 5, 10, -1, -2, -5, -10};
    for (int k = 0; k < 8; k++) begin
      wr(`SSS_OFF_STEP, k, 1'b0);
      wr(`SSS_OFF_CTRL, 32'h2, 1'b0);
      repeat (2) @(negedge clk);
      chk(lvl(), 32'h0);
      waitSig(1, c);
      repeat (2) @(negedge clk);
      chk(lvl(), stepv[k]);
    end
  endtask
  task automatic t_cap();
    int c, n;
    logic [31:0] cnt0;
    logic        e;
    for (int m = 0; m < 2; m++) begin
      n = 0;
      wr(`SSS_OFF_CTRL, (m == 0) ? 32'h6 : 32'h2, 1'b0);
      sss_host_model_i.xfer(1'b0, `SSS_OFF_COUNT, 32'h0, cnt0, e);
      repeat (4) begin
        waitSig(0, c);
        n += (readingValid === 1'b1);
      end
      chk(n, (m == 0) ? 32'd2 : 32'd4);
      rdChk(`SSS_OFF_COUNT, cnt0 + ((m == 0) ? 32'd2 : 32'd4));
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults();
    t_refuse();
    t_timing();
    t_stair();
    wr(`SSS_OFF_CTRL, 32'h8, 1'b0);
    t_defaults();
    t_codes();
    t_cap();
    end_of_test();
  end
  // Whole run is a few thousand clocks; this span is far beyond it
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule // sss_sequencer_tb
`default_nettype wire
